// File: common/pmc_pkg.sv
// Constants and types shared by the output macrocell configuration block.
// Assumes a single 20 MHz clock domain; all values are static except pins.
package pmc_pkg;

	localparam int MC_COUNT     = 8;
	localparam int PT_PER_MC    = 8;
	localparam int PT_OE_IDX    = 0;
	localparam int IN_PIN_COUNT = 10;
	localparam int CLK_PIN_IDX  = 0;
	localparam int OE_PIN_IDX   = 9;
	localparam int OUTER_LO     = 0;
	localparam int OUTER_HI     = 7;
	localparam int CENTRE_A     = 3;
	localparam int CENTRE_B     = 4;
	localparam int SIG_BYTES    = 8;
	localparam int SIG_AW       = 3;
	localparam int CFG_W        = 18;

	localparam logic [7:0] OUTER_MASK  = 8'h81;
	localparam logic [7:0] CENTRE_MASK = 8'h18;
	localparam logic [7:0] MC_RST      = 8'h00;
	localparam logic [7:0] BYTE_RST    = 8'h00;
	localparam logic [CFG_W-1:0] CFG_RST = 18'h00000;

	typedef enum logic [1:0] {
		MODE_REG  = 2'b00,
		MODE_CPLX = 2'b01,
		MODE_SIMP = 2'b10
	} pmc_mode_t;

endpackage : pmc_pkg

// File: design/pmc_pin_keeper.sv
// Weak keeper for a group of pins: holds the last level seen on each pin.
// Assumes drive-present flags are synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module pmc_pin_keeper #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] extDrv,
	input  wire logic [WIDTH-1:0] extLvl,
	input  wire logic [WIDTH-1:0] ownOe,
	input  wire logic [WIDTH-1:0] ownLvl,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	// Own buffer first, then any outside driver; keeper always loses
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (ownOe[i]) begin
				level_next[i] = ownLvl[i]; // [RQ1]
			end else if (extDrv[i]) begin
				level_next[i] = extLvl[i]; // [RQ1]
			end else begin
				level_next[i] = level_reg[i]; // [RQ1]
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			level_reg <= '0;
		end else begin
			level_reg <= level_next;
		end
	end

	assign level = level_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Per pin, so one undriven pin is watched while others are driven
	chk_keeper_holds: assert property ( // [RQ1]
		1'b1 |=> (((level_reg ^ $past(level_reg))
			& $past(~ownOe & ~extDrv)) == '0))
		else $error("keeper lost an undriven pin level");

endmodule : pmc_pin_keeper
`default_nettype wire

// File: design/pmc_config.sv
// Output macrocell configuration logic: mode, product-term use, enables,
// feedback routing, signature storage and readout protection.
// Assumes static configuration ports and pins synchronous to ref_clk.
//
// Function
// RQ1 - Undriven input and I/O pins hold their last level, any driver wins.
// RQ2 - Eight macrocells, each registered, comb I/O, comb output or input.
// RQ3 - One global setting picks registered, complex or simple mode.
// RQ4 - An eight-byte user signature is readable whatever the fuse state.
// RQ5 - A programmed security fuse blocks configuration readout only.
// RQ6 - Registered mode makes pin one the clock and pin eleven the enable.
// RQ7 - Registered cells clock from the clock pin, enable from the OE pin.
// RQ8 - Registered-mode comb cells take enable from a term, sum seven terms.
// RQ9 - A cell set up as input has its output buffer always disabled; outer cells in complex mode and centre cells in simple mode ignore the setting.
// RQ10 - Complex mode feeds clock and OE pins through the outer cells' paths.
// RQ11 - Complex mode feeds the six inner pin levels back to the array.
// RQ12 - Complex mode sums seven terms and enables from one separate term.
// RQ13 - Simple mode sums eight terms, clock and OE pins are plain inputs.
// RQ14 - Simple mode centre cells are always-on outputs without feedback.
// RQ15 - The configurer picks the mode matching register and enable use.
// RQ16 - Reset clears every macrocell register, so registered pins go high.
// RQ17 - Mode and cell configuration are static, never changed by logic.
`timescale 1ns/1ns
`default_nettype none
module pmc_config
	import pmc_pkg::*;
#(
	parameter int NUM_MC = MC_COUNT
) (
	input  wire logic                      ref_clk,
	input  wire logic                      reset,
	input  wire logic [1:0]                modeSel,
	input  wire logic [NUM_MC-1:0]         mcRegCfg,
	input  wire logic [NUM_MC-1:0]         mcInputCfg,
	input  wire logic                      secFuse,
	input  wire logic [NUM_MC*PT_PER_MC-1:0] ptIn,
	input  wire logic [IN_PIN_COUNT-1:0]   inPinLvl,
	input  wire logic [IN_PIN_COUNT-1:0]   inPinDrv,
	input  wire logic [NUM_MC-1:0]         ioPinLvl,
	input  wire logic [NUM_MC-1:0]         ioPinDrv,
	input  wire logic                      sigWe,
	input  wire logic [SIG_AW-1:0]         sigWrAddr,
	input  wire logic [7:0]                sigWrData,
	input  wire logic                      sigRdReq,
	input  wire logic [SIG_AW-1:0]         sigAddr,
	input  wire logic                      cfgRdReq,
	output logic      [NUM_MC-1:0]         ioOut,
	output logic      [NUM_MC-1:0]         ioOe,
	output logic      [IN_PIN_COUNT-1:0]   arrayPin,
	output logic      [NUM_MC-1:0]         arrayFb,
	output logic      [7:0]                sigData,
	output logic                           sigValid,
	output logic      [CFG_W-1:0]          cfgData,
	output logic                           cfgValid,
	output logic                           cfgDenied
);
	function automatic logic sumTerm(input logic [PT_PER_MC-1:0] pts,
	                                 input logic oeTaken);
		logic [PT_PER_MC-1:0] used;
		used = pts;
		if (oeTaken) begin
			used[PT_OE_IDX] = 1'b0;
		end
		return |used;
	endfunction : sumTerm

	logic [IN_PIN_COUNT-1:0] inLvl;
	logic [NUM_MC-1:0]       ioLvl;
	logic [NUM_MC-1:0]       sum8Vec;
	logic [NUM_MC-1:0]       sum7Vec;
	logic [NUM_MC-1:0]       ptOeVec;
	logic                    clkRise;
	pmc_mode_t               mode;

	logic [NUM_MC-1:0]       mcFf_reg,    mcFf_next;
	logic                    clkPrev_reg, clkPrev_next;
	logic [NUM_MC-1:0]       ioOut_reg,   ioOut_next;
	logic [NUM_MC-1:0]       ioOe_reg,    ioOe_next;
	logic [IN_PIN_COUNT-1:0] arrayPin_reg, arrayPin_next;
	logic [NUM_MC-1:0]       arrayFb_reg, arrayFb_next;
	logic [7:0]              sigMem [SIG_BYTES];
	logic [7:0]              sigData_reg, sigData_next;
	logic                    sigValid_reg, sigValid_next;
	logic [CFG_W-1:0]        cfgData_reg, cfgData_next;
	logic                    cfgValid_reg, cfgValid_next;
	logic                    cfgDenied_reg, cfgDenied_next;

	pmc_pin_keeper #(.WIDTH(IN_PIN_COUNT)) inKeeper (
		.ref_clk (ref_clk),
		.reset   (reset),
		.extDrv  (inPinDrv),
		.extLvl  (inPinLvl),
		.ownOe   ('0),
		.ownLvl  ('0),
		.level   (inLvl)
	);

	pmc_pin_keeper #(.WIDTH(NUM_MC)) ioKeeper (
		.ref_clk (ref_clk),
		.reset   (reset),
		.extDrv  (ioPinDrv),
		.extLvl  (ioPinLvl),
		.ownOe   (ioOe_reg),
		.ownLvl  (ioOut_reg),
		.level   (ioLvl)
	);

	// Mode is a static setting; the array never writes it
	assign mode = pmc_mode_t'(modeSel); // [RQ3] [RQ17]

	always_comb begin
		for (int i = 0; i < NUM_MC; i++) begin
			sum8Vec[i] = sumTerm(ptIn[i*PT_PER_MC +: PT_PER_MC], 1'b0);
			sum7Vec[i] = sumTerm(ptIn[i*PT_PER_MC +: PT_PER_MC], 1'b1);
			ptOeVec[i] = ptIn[i*PT_PER_MC + PT_OE_IDX];
		end
	end

	// Pin clock sampled on ref_clk, so it must be well below 10 MHz
	always_comb begin
		clkPrev_next = inLvl[CLK_PIN_IDX];
		clkRise = inLvl[CLK_PIN_IDX] & ~clkPrev_reg; // [RQ6]
	end

	// Per-cell output, enable and feedback selection [RQ2]
	always_comb begin
		mcFf_next = mcFf_reg;
		ioOut_next = '0;
		ioOe_next = '0;
		arrayFb_next = '0;
		arrayPin_next = inLvl;
		for (int i = 0; i < NUM_MC; i++) begin
			unique case (mode)
				MODE_REG: begin
					if (mcInputCfg[i]) begin
						ioOe_next[i] = 1'b0; // [RQ9]
						arrayFb_next[i] = ioLvl[i];
					end else if (mcRegCfg[i]) begin
						if (clkRise) begin
							mcFf_next[i] = sum8Vec[i]; // [RQ7]
						end
						// Inverting buffer: cleared flop drives pin high
						ioOut_next[i] = ~mcFf_reg[i]; // [RQ16]
						ioOe_next[i] = ~inLvl[OE_PIN_IDX]; // [RQ7]
						arrayFb_next[i] = mcFf_reg[i];
					end else begin
						ioOut_next[i] = sum7Vec[i]; // [RQ8]
						ioOe_next[i] = ptOeVec[i]; // [RQ8]
						arrayFb_next[i] = ioLvl[i];
					end
				end
				MODE_CPLX: begin
					ioOut_next[i] = sum7Vec[i]; // [RQ12]
					if (OUTER_MASK[i]) begin
						ioOe_next[i] = ptOeVec[i]; // [RQ12]
						arrayFb_next[i] = (i == OUTER_LO) ?
							inLvl[CLK_PIN_IDX] : inLvl[OE_PIN_IDX]; // [RQ10]
					end else begin
						ioOe_next[i] = mcInputCfg[i] ?
							1'b0 : ptOeVec[i]; // [RQ9] [RQ12]
						arrayFb_next[i] = ioLvl[i]; // [RQ11]
					end
				end
				MODE_SIMP: begin
					ioOut_next[i] = sum8Vec[i]; // [RQ13]
					if (CENTRE_MASK[i]) begin
						ioOe_next[i] = 1'b1; // [RQ14]
						arrayFb_next[i] = 1'b0; // [RQ14]
					end else begin
						ioOe_next[i] = ~mcInputCfg[i]; // [RQ9] [RQ13]
						// Level arrives through the cell's own feedback path
						arrayFb_next[i] = ioLvl[i]; // [RQ14]
					end
				end
				default: begin
					// Illegal mode code keeps every buffer off
					ioOe_next[i] = 1'b0;
				end
			endcase
		end
		unique case (mode)
			MODE_REG: begin
				arrayPin_next[CLK_PIN_IDX] = 1'b0; // [RQ6]
				arrayPin_next[OE_PIN_IDX] = 1'b0; // [RQ6]
			end
			MODE_CPLX: begin
				// These two reach the array through the outer paths
				arrayPin_next[CLK_PIN_IDX] = 1'b0; // [RQ10]
				arrayPin_next[OE_PIN_IDX] = 1'b0; // [RQ10]
			end
			MODE_SIMP: begin
				arrayPin_next = inLvl; // [RQ13]
			end
			default: begin
				arrayPin_next = '0;
			end
		endcase
	end

	// Signature readout ignores the fuse; configuration readout does not
	always_comb begin
		sigValid_next = sigRdReq;
		sigData_next = sigRdReq ? sigMem[sigAddr] : sigData_reg; // [RQ4]
		cfgValid_next = cfgRdReq;
		cfgDenied_next = cfgDenied_reg;
		cfgData_next = cfgData_reg;
		if (cfgRdReq) begin
			cfgDenied_next = secFuse; // [RQ5]
			cfgData_next = secFuse ? CFG_RST :
				{modeSel, mcRegCfg, mcInputCfg}; // [RQ5]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sigWe) begin
			sigMem[sigWrAddr] <= sigWrData; // [RQ4]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mcFf_reg      <= MC_RST; // [RQ16]
			clkPrev_reg   <= 1'b0;
			ioOut_reg     <= MC_RST;
			ioOe_reg      <= MC_RST;
			arrayPin_reg  <= '0;
			arrayFb_reg   <= MC_RST;
			sigData_reg   <= BYTE_RST;
			sigValid_reg  <= 1'b0;
			cfgData_reg   <= CFG_RST;
			cfgValid_reg  <= 1'b0;
			cfgDenied_reg <= 1'b0;
		end else begin
			mcFf_reg      <= mcFf_next;
			clkPrev_reg   <= clkPrev_next;
			ioOut_reg     <= ioOut_next;
			ioOe_reg      <= ioOe_next;
			arrayPin_reg  <= arrayPin_next;
			arrayFb_reg   <= arrayFb_next;
			sigData_reg   <= sigData_next;
			sigValid_reg  <= sigValid_next;
			cfgData_reg   <= cfgData_next;
			cfgValid_reg  <= cfgValid_next;
			cfgDenied_reg <= cfgDenied_next;
		end
	end

	assign ioOut     = ioOut_reg;
	assign ioOe      = ioOe_reg;
	assign arrayPin  = arrayPin_reg;
	assign arrayFb   = arrayFb_reg;
	assign sigData   = sigData_reg;
	assign sigValid  = sigValid_reg;
	assign cfgData   = cfgData_reg;
	assign cfgValid  = cfgValid_reg;
	assign cfgDenied = cfgDenied_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	chk_input_oe_off: assert property ( // [RQ9]
		(mode != MODE_SIMP) |=> ((ioOe_reg & $past(mcInputCfg)
			& ~OUTER_MASK) == '0))
		else $error("input cell drove its pin");
	chk_reg_pins_blocked: assert property ( // [RQ6]
		(mode == MODE_REG) |=> (!arrayPin_reg[CLK_PIN_IDX]
			&& !arrayPin_reg[OE_PIN_IDX]))
		else $error("clock or enable pin reached the array");
	chk_ff_capture: assert property ( // [RQ7]
		(mode == MODE_REG && clkRise) |=> (((mcFf_reg ^ $past(sum8Vec))
			& $past(mcRegCfg & ~mcInputCfg)) == '0))
		else $error("register missed eight-term sum on clock edge");
	chk_reg_oe_pin: assert property ( // [RQ7]
		(mode == MODE_REG) |=> (((ioOe_reg
			^ {NUM_MC{~$past(inLvl[OE_PIN_IDX])}})
			& $past(mcRegCfg & ~mcInputCfg)) == '0))
		else $error("registered enable not from enable pin");
	chk_cplx_term_oe: assert property ( // [RQ12]
		(mode == MODE_CPLX) |=> (((ioOe_reg ^ $past(ptOeVec))
			& $past(~mcInputCfg | OUTER_MASK)) == '0)
			&& (ioOut_reg == $past(sum7Vec)))
		else $error("complex cell enable or sum wrong");
	chk_cplx_outer_fb: assert property ( // [RQ10]
		(mode == MODE_CPLX) |=> (arrayFb_reg[OUTER_LO]
			== $past(inLvl[CLK_PIN_IDX])) && (arrayFb_reg[OUTER_HI]
			== $past(inLvl[OE_PIN_IDX])))
		else $error("outer feedback not carrying clock and enable pins");
	chk_centre_always_on: assert property ( // [RQ14]
		(mode == MODE_SIMP) |=> (ioOe_reg[CENTRE_A] && ioOe_reg[CENTRE_B]
			&& !arrayFb_reg[CENTRE_A] && !arrayFb_reg[CENTRE_B]))
		else $error("centre cell not an always-on output");
	chk_simple_sum8: assert property ( // [RQ13]
		(mode == MODE_SIMP) |=> (ioOut_reg == $past(sum8Vec)))
		else $error("simple cell not summing eight terms");
	chk_secure_block: assert property ( // [RQ5]
		(cfgRdReq && secFuse) |=> (cfgValid_reg && cfgDenied_reg
			&& cfgData_reg == CFG_RST))
		else $error("configuration read while fuse programmed");
	chk_sig_readable: assert property ( // [RQ4]
		(sigRdReq && !sigWe) |=> (sigValid_reg
			&& sigData_reg == $past(sigMem[sigAddr])))
		else $error("signature read failed");
	// Own disable, else the default one would mute this check
	chk_reset_clears: assert property ( // [RQ16]
		@(posedge ref_clk) disable iff (1'b0)
		reset |=> (mcFf_reg == MC_RST))
		else $error("reset left a macrocell register set");

	cov_reg_clock: cover property (mode == MODE_REG && clkRise);
	cov_cfg_denied: cover property (cfgRdReq && secFuse);
	cov_sig_read: cover property (sigRdReq && secFuse);
	cov_simple_mode: cover property (mode == MODE_SIMP && ioOe_reg != '0);

endmodule : pmc_config
`default_nettype wire

// File: testbench/pmc_board_model.sv
// Board logic on the far side of the pins.
// Assumes ioOe from the block; changes pins off the falling edge.
`timescale 1ns/1ns
`default_nettype none
module pmc_board_model
	import pmc_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic [IN_PIN_COUNT-1:0] wantInLvl,
	input  wire logic [IN_PIN_COUNT-1:0] wantInDrv,
	input  wire logic [MC_COUNT-1:0]     wantIoLvl,
	input  wire logic [MC_COUNT-1:0]     wantIoDrv,
	input  wire logic [MC_COUNT-1:0]     ioOe,
	output logic      [IN_PIN_COUNT-1:0] inPinLvl,
	output logic      [IN_PIN_COUNT-1:0] inPinDrv,
	output logic      [MC_COUNT-1:0]     ioPinLvl,
	output logic      [MC_COUNT-1:0]     ioPinDrv
);
	logic [IN_PIN_COUNT-1:0] inLast;
	logic [MC_COUNT-1:0]     ioLast;
	logic [MC_COUNT-1:0]     ioDrv;

	initial begin
		inPinLvl = 10'h000;
		inPinDrv = 10'h000;
		ioPinLvl = 8'h00;
		ioPinDrv = 8'h00;
		inLast = 10'h000;
		ioLast = 8'h00;
	end

	// Never fight the block's own buffer
	assign ioDrv = wantIoDrv & ~ioOe;

	// Released lines show the inverse, so only the keeper can hold them
	always @(negedge ref_clk) begin
		inPinDrv <= wantInDrv;
		ioPinDrv <= ioDrv;
		inPinLvl <= (wantInDrv & wantInLvl) | (~wantInDrv & ~inLast);
		ioPinLvl <= (ioDrv & wantIoLvl) | (~ioDrv & ~ioLast);
		inLast <= (wantInDrv & wantInLvl) | (~wantInDrv & inLast);
		ioLast <= (ioDrv & wantIoLvl) | (~ioDrv & ioLast);
	end
endmodule : pmc_board_model
`default_nettype wire

// File: testbench/pmc_config_tb.sv
// Self-checking bench for the macrocell configuration block.
// Assumes the board model stands on the pins; config changes under reset.
`timescale 1ns/1ns
`default_nettype none
module pmc_config_tb
	import pmc_pkg::*;
();
	logic        ref_clk = 1'b0, reset = 1'b1, secFuse = 1'b0;
	logic        sigWe = 1'b0, sigRdReq = 1'b0, cfgRdReq = 1'b0;
	logic [1:0]  modeSel = 2'h2;
	logic [7:0]  mcRegCfg = 8'h00, mcInputCfg = 8'h00, sigWrData = 8'h00;
	logic [63:0] ptIn = 64'h0;
	logic [2:0]  sigWrAddr = 3'h0, sigAddr = 3'h0;
	logic [9:0]  inW = 10'h000, inD = 10'h3ff, inPinLvl, inPinDrv, arrayPin;
	logic [7:0]  ioW = 8'h00, ioD = 8'hff, ioPinLvl, ioPinDrv;
	logic [7:0]  ioOut, ioOe, arrayFb, sigData;
	logic        sigValid, cfgValid, cfgDenied;
	logic [17:0] cfgData;
	logic [7:0]  sigMem [8];
	int          seed = 32'ha0121094;
	int          num_errors = 0, samples_checked = 0, cycles = 0;

	always #25 ref_clk = ~ref_clk;

	pmc_config pmc_config_i (.ref_clk, .reset, .modeSel, .mcRegCfg,
		.mcInputCfg, .secFuse, .ptIn, .inPinLvl, .inPinDrv, .ioPinLvl,
		.ioPinDrv, .sigWe, .sigWrAddr, .sigWrData, .sigRdReq, .sigAddr,
		.cfgRdReq, .ioOut, .ioOe, .arrayPin, .arrayFb, .sigData, .sigValid,
		.cfgData, .cfgValid, .cfgDenied);

	pmc_board_model pmc_board_model_i (.ref_clk, .wantInLvl(inW),
		.wantInDrv(inD), .wantIoLvl(ioW), .wantIoDrv(ioD), .ioOe, .inPinLvl,
		.inPinDrv, .ioPinLvl, .ioPinDrv);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Far above the two hundred or so cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	function automatic logic [7:0] sumOf(logic [63:0] pt, int lo);
		logic [7:0] r;
		for (int k = 0; k < 8; k++) r[k] = |(pt[8*k +: 8] >> lo);
		return r;
	endfunction : sumOf

	function automatic logic [7:0] oeTerm(logic [63:0] pt);
		logic [7:0] r;
		for (int k = 0; k < 8; k++) r[k] = pt[8*k];
		return r;
	endfunction : oeTerm

	// Static config only moves while reset holds
	task automatic setup(input logic [1:0] m, input logic [7:0] r, i);
		reset = 1'b1;
		modeSel = m;
		mcRegCfg = r;
		mcInputCfg = i;
		ptIn = {$random(seed), $random(seed)};
		ioW = 8'($random(seed));
		inW = 10'($random(seed)) & ((m == 2'h0) ? 10'h1fe : 10'h3ff);
		tick(3);
		reset = 1'b0;
		tick(6);
	endtask : setup

	task automatic read_cfg();
		cfgRdReq = 1'b1;
		tick(1);
		// Valid stands one cycle only, so look before it drops
		check("cfgValid", 32'(cfgValid), 32'h1);
		check("cfgData", 32'(cfgData),
			secFuse ? 32'h0 : 32'({modeSel, mcRegCfg, mcInputCfg}));
		check("cfgDenied", 32'(cfgDenied), 32'(secFuse));
		cfgRdReq = 1'b0;
	endtask : read_cfg

	initial begin : main
		logic [7:0] oe, out, pin, rg, cb;
		for (int n = 0; n < 8; n++) begin
			// Mode matches the register and enable use chosen
			setup(n[0] ? 2'h1 : 2'h2, 8'h00, 8'($random(seed)));
			secFuse = n[1];
			read_cfg();
			if (modeSel == 2'h2) begin
				oe = CENTRE_MASK | ~mcInputCfg;
				out = sumOf(ptIn, 0);
			end else begin
				oe = oeTerm(ptIn) & ~(mcInputCfg & ~OUTER_MASK);
				out = sumOf(ptIn, 1);
			end
			pin = (oe & out) | (~oe & ioW);
			check("ioOe", 32'(ioOe), 32'(oe));
			check("ioOut", 32'(ioOut), 32'(out));
			if (modeSel == 2'h2) begin
				check("arrayFb", 32'(arrayFb), 32'(pin & ~CENTRE_MASK));
				check("arrayPin", 32'(arrayPin), 32'(inW));
			end else begin
				check("arrayFb", 32'(arrayFb), 32'((pin & ~OUTER_MASK)
					| {inW[9], 6'h00, inW[0]}));
				check("arrayPin", 32'(arrayPin), 32'(inW & 10'h1fe));
			end
			$display("round %0d mode %0d done", n, modeSel);
		end
		for (int n = 0; n < 3; n++) begin
			rg = 8'($random(seed));
			setup(2'h0, rg, 8'($random(seed)) & ~rg);
			rg = mcRegCfg & ~mcInputCfg;
			cb = ~mcRegCfg & ~mcInputCfg;
			check("ioOe", 32'(ioOe), 32'(rg | (cb & oeTerm(ptIn))));
			check("ioOut", 32'(ioOut & rg), 32'(rg));
			check("ioOut", 32'(ioOut & cb), 32'(sumOf(ptIn, 1) & cb));
			check("arrayPin", 32'(arrayPin), 32'(inW & 10'h1fe));
			inW[0] = 1'b1;
			tick(6);
			check("ioOut", 32'(ioOut & rg), 32'(~sumOf(ptIn, 0) & rg));
			check("arrayFb", 32'(arrayFb & rg), 32'(sumOf(ptIn, 0) & rg));
			inW[9] = 1'b1;
			tick(6);
			check("ioOe", 32'(ioOe), 32'(cb & oeTerm(ptIn)));
			$display("registered round %0d done", n);
		end
		setup(2'h3, 8'h00, 8'h00);
		check("ioOe", 32'(ioOe), 32'h0);
		check("arrayPin", 32'(arrayPin), 32'h0);
		read_cfg();
		$display("illegal mode test done");
		setup(2'h2, 8'h00, 8'h01);
		ioW[0] = 1'b1;
		inW[5] = 1'b1;
		tick(6);
		ioD[0] = 1'b0;
		inD[5] = 1'b0;
		tick(6);
		check("arrayFb", 32'(arrayFb[0]), 32'h1);
		check("arrayPin", 32'(arrayPin[5]), 32'h1);
		ioD = 8'hff;
		inD = 10'h3ff;
		$display("keeper test done");
		for (int a = 0; a < 8; a++) begin
			sigMem[a] = 8'($random(seed));
			sigWe = 1'b1;
			sigWrAddr = a[2:0];
			sigWrData = sigMem[a];
			tick(1);
		end
		sigWe = 1'b0;
		for (int a = 0; a < 16; a++) begin
			secFuse = a[3];
			sigRdReq = 1'b1;
			sigAddr = a[2:0];
			tick(1);
			check("sigValid", 32'(sigValid), 32'h1);
			check("sigData", 32'(sigData), 32'(sigMem[a[2:0]]));
		end
		sigRdReq = 1'b0;
		$display("signature test done");
		report_and_stop();
	end
endmodule : pmc_config_tb
`default_nettype wire
